// >>> core/spmc_defs.svh
`ifndef SPMC_DEFS_SVH
`define SPMC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPMC_CTRL_OFS 8'h00
`define SPMC_PAGE_OFS 8'h04
`define SPMC_STAT_OFS 8'h08
`define SPMC_FUSE_OFS 8'h0C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SPMC_CTRL_EN 0
`define SPMC_CTRL_ERASE 1
`define SPMC_CTRL_WRITE 2
`define SPMC_CTRL_RWWEN 4
`define SPMC_CTRL_BUSY 6

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SPMC_STAT_ACTIVE 0
`define SPMC_STAT_STALL 1
`define SPMC_STAT_RWWBLK 2
`define SPMC_STAT_IGNORED 3
`define SPMC_STAT_LOCKED 4

// ----------------------------------------
// Fuse view fields and sizes
// ----------------------------------------
`define SPMC_FUSE_BOOT_SIZE_FUSES_LSB 0
`define SPMC_FUSE_APPLK_LSB 2
`define SPMC_FUSE_LDRLK_LSB 4
`define SPMC_LOADER_MIN_PAGES 4
`define SPMC_ARM_CYCLES 3'h4
`define SPMC_LOCK_WR_BIT 0

`endif

// >>> core/spmc_pkg.sv
package spmc_pkg;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SPMC_IDLE = 2'b00,
		SPMC_RWW_OP = 2'b01,
		SPMC_HALT_OP = 2'b10
	} spmc_state_type;

	// Command decoded from the control register
	typedef enum logic [1:0] {
		SPMC_CMD_NONE = 2'b00,
		SPMC_CMD_ERASE = 2'b01,
		SPMC_CMD_WRITE = 2'b10
	} spmc_cmd_type;

endpackage

// >>> core/spmc_core.sv
`include "spmc_defs.svh"

module spmc_core
	import spmc_pkg::*;
#(
	parameter int PAGE_AW = 10,
	parameter int HALT_PAGES = 64,
	parameter int OP_CYCLES = 5000
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	// Core side
	input wire logic i_spm_exec,
	input wire logic [PAGE_AW-1:0] i_spm_pc_page,
	input wire logic [PAGE_AW-1:0] i_fetch_page,
	output logic o_fetch_valid,
	output logic o_core_stall,
	// Fuses and lock bits
	input wire logic [1:0] i_boot_size_fuses,
	input wire logic [1:0] i_app_lock_bits,
	input wire logic [1:0] i_loader_lock_bits,
	// Flash array
	output logic o_flash_erase,
	output logic o_flash_write,
	output logic [PAGE_AW-1:0] o_flash_page
);

	// ----------------------------------------
	// Region geometry
	// ----------------------------------------
	localparam int CNT_W = $clog2(OP_CYCLES + 1);
	localparam logic [PAGE_AW:0] TOP = {1'b1, {PAGE_AW{1'b0}}};
	localparam logic [PAGE_AW:0] HALT_SIZE = (PAGE_AW + 1)'(HALT_PAGES);
	localparam logic [PAGE_AW-1:0] HALT_BASE = PAGE_AW'(TOP - HALT_SIZE);
	localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(OP_CYCLES - 1);
	localparam logic [PAGE_AW:0] LDR_MIN = (PAGE_AW + 1)'(`SPMC_LOADER_MIN_PAGES);

	logic [PAGE_AW:0] ldr_size;
	logic [PAGE_AW:0] ldr_clamped;
	logic [PAGE_AW-1:0] ldr_base;
	logic spm_in_loader;
	logic tgt_in_halt;
	logic tgt_in_loader;
	logic tgt_locked;

	// Loader size from fuses, largest for code 00
	always_comb begin
		unique case (i_boot_size_fuses)
			2'b11: ldr_size = LDR_MIN;
			2'b10: ldr_size = LDR_MIN << 1;
			2'b01: ldr_size = LDR_MIN << 2;
			2'b00: ldr_size = LDR_MIN << 3;
		endcase
	end

	// Clamp keeps the loader inside the halting region for any geometry
	assign ldr_clamped = (ldr_size > HALT_SIZE) ? HALT_SIZE : ldr_size;
	assign ldr_base = PAGE_AW'(TOP - ldr_clamped);
	assign spm_in_loader = (i_spm_pc_page >= ldr_base);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	spmc_state_type state;
	spmc_cmd_type arm_cmd;
	logic [2:0] arm_cnt;
	logic [PAGE_AW-1:0] page_reg;
	logic [CNT_W-1:0] op_cnt;
	logic rww_blocked;
	logic ignored;
	logic lock_refused;
	logic start_op;
	logic spm_refused;
	logic lock_hit;

	// Fixed halting boundary, fuses play no part in it; the loader boundary follows the fuses
	assign tgt_in_halt = (page_reg >= HALT_BASE);
	assign tgt_in_loader = (page_reg >= ldr_base);
	// Each section checks only its own group, cleared bit blocks writing
	assign tgt_locked = tgt_in_loader ? !i_loader_lock_bits[`SPMC_LOCK_WR_BIT]
		: !i_app_lock_bits[`SPMC_LOCK_WR_BIT];
	assign lock_hit = i_spm_exec && (arm_cnt != 3'h0) && (arm_cmd != SPMC_CMD_NONE)
		&& spm_in_loader && (state == SPMC_IDLE) && tgt_locked;
	// Any page may be the target; the caller's location and the target section's lock bit gate it
	assign start_op = i_spm_exec && (arm_cnt != 3'h0) && (arm_cmd != SPMC_CMD_NONE)
		&& spm_in_loader && (state == SPMC_IDLE) && !tgt_locked;
	assign spm_refused = i_spm_exec && !spm_in_loader;

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	logic wr_pend;
	logic [7:0] wr_ofs;
	logic addr_ok;
	logic wr_ctrl;
	logic wr_page;
	logic wr_stat;
	logic [31:0] rd_value;

	assign addr_ok = i_hsel && i_htrans[1] && i_hready;
	assign wr_ctrl = wr_pend && (wr_ofs == `SPMC_CTRL_OFS);
	assign wr_page = wr_pend && (wr_ofs == `SPMC_PAGE_OFS);
	assign wr_stat = wr_pend && (wr_ofs == `SPMC_STAT_OFS);
	// Zero wait states; every transfer answers OKAY
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;

	// Address phase capture for writes
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			wr_pend <= 1'b0;
			wr_ofs <= 8'h00;
		end else begin
			wr_pend <= addr_ok && i_hwrite;
			wr_ofs <= i_haddr[7:0];
		end
	end

	// Read mux, unmapped offsets read zero
	always_comb begin
		rd_value = 32'h0000_0000;
		unique case (i_haddr[7:0])
			`SPMC_CTRL_OFS: begin
				rd_value[`SPMC_CTRL_EN] = (arm_cnt != 3'h0);
				rd_value[`SPMC_CTRL_ERASE] = (arm_cmd == SPMC_CMD_ERASE);
				rd_value[`SPMC_CTRL_WRITE] = (arm_cmd == SPMC_CMD_WRITE);
				rd_value[`SPMC_CTRL_BUSY] = rww_blocked;
			end
			`SPMC_PAGE_OFS: rd_value[PAGE_AW-1:0] = page_reg;
			`SPMC_STAT_OFS: begin
				rd_value[`SPMC_STAT_ACTIVE] = (state != SPMC_IDLE);
				rd_value[`SPMC_STAT_STALL] = o_core_stall;
				rd_value[`SPMC_STAT_RWWBLK] = rww_blocked;
				rd_value[`SPMC_STAT_IGNORED] = ignored;
				rd_value[`SPMC_STAT_LOCKED] = lock_refused;
			end
			`SPMC_FUSE_OFS: begin
				rd_value[`SPMC_FUSE_BOOT_SIZE_FUSES_LSB +: 2] = i_boot_size_fuses;
				rd_value[`SPMC_FUSE_APPLK_LSB +: 2] = i_app_lock_bits;
				rd_value[`SPMC_FUSE_LDRLK_LSB +: 2] = i_loader_lock_bits;
			end
			default: rd_value = 32'h0000_0000;
		endcase
	end

	// Read data registered at the address phase, stands in the data phase
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_hrdata <= 32'h0000_0000;
		end else if (addr_ok && !i_hwrite) begin
			o_hrdata <= rd_value;
		end
	end

	// ----------------------------------------
	// Command arming window
	// ----------------------------------------
	// Window counts down so a stray store instruction later does nothing
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			arm_cnt <= 3'h0;
			arm_cmd <= SPMC_CMD_NONE;
		end else if (wr_ctrl && i_hwdata[`SPMC_CTRL_EN]) begin
			arm_cnt <= `SPMC_ARM_CYCLES;
			if (i_hwdata[`SPMC_CTRL_ERASE] && !i_hwdata[`SPMC_CTRL_WRITE]) begin
				arm_cmd <= SPMC_CMD_ERASE;
			end else if (i_hwdata[`SPMC_CTRL_WRITE] && !i_hwdata[`SPMC_CTRL_ERASE]) begin
				arm_cmd <= SPMC_CMD_WRITE;
			end else begin
				arm_cmd <= SPMC_CMD_NONE;
			end
		end else if (i_spm_exec || arm_cnt == 3'h1) begin
			arm_cnt <= 3'h0;
			arm_cmd <= SPMC_CMD_NONE;
		end else if (arm_cnt != 3'h0) begin
			arm_cnt <= arm_cnt - 3'h1;
		end
	end

	// Page address register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			page_reg <= '0;
		end else if (wr_page) begin
			page_reg <= i_hwdata[PAGE_AW-1:0];
		end
	end

	// ----------------------------------------
	// Operation sequencer
	// ----------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			state <= SPMC_IDLE;
			op_cnt <= '0;
		end else begin
			unique case (state)
				SPMC_IDLE: begin
					op_cnt <= '0;
					if (start_op) begin
						state <= tgt_in_halt ? SPMC_HALT_OP : SPMC_RWW_OP;
					end
				end
				SPMC_RWW_OP, SPMC_HALT_OP: begin
					// Leave only after the full operation time
					if (op_cnt == OP_LAST) begin
						state <= SPMC_IDLE;
						op_cnt <= '0;
					end else begin
						op_cnt <= op_cnt + CNT_W'(1);
					end
				end
				default: state <= SPMC_IDLE;
			endcase
		end
	end

	// Flash strobes and latched target page
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_flash_erase <= 1'b0;
			o_flash_write <= 1'b0;
			o_flash_page <= '0;
		end else begin
			o_flash_erase <= start_op && (arm_cmd == SPMC_CMD_ERASE);
			o_flash_write <= start_op && (arm_cmd == SPMC_CMD_WRITE);
			if (start_op) begin
				o_flash_page <= page_reg;
			end
		end
	end

	// Block stays until software re-enables and nothing runs; set wins
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			rww_blocked <= 1'b0;
		end else if (start_op && !tgt_in_halt) begin
			rww_blocked <= 1'b1;
		end else if (wr_ctrl && i_hwdata[`SPMC_CTRL_RWWEN] && state == SPMC_IDLE) begin
			rww_blocked <= 1'b0;
		end
	end

	// Sticky refusal flags, write one to clear; new event wins
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			ignored <= 1'b0;
			lock_refused <= 1'b0;
		end else begin
			if (spm_refused) begin
				ignored <= 1'b1;
			end else if (wr_stat && i_hwdata[`SPMC_STAT_IGNORED]) begin
				ignored <= 1'b0;
			end
			if (lock_hit) begin
				lock_refused <= 1'b1;
			end else if (wr_stat && i_hwdata[`SPMC_STAT_LOCKED]) begin
				lock_refused <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Fetch arbitration
	// ----------------------------------------
	// Halting region code is readable unless a halting operation runs
	assign o_core_stall = (state == SPMC_HALT_OP);
	assign o_fetch_valid = (i_fetch_page >= HALT_BASE) ? (state != SPMC_HALT_OP)
		: (!rww_blocked && state == SPMC_IDLE);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);

	logic [CNT_W-1:0] stall_len;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			stall_len <= '0;
		end else begin
			stall_len <= o_core_stall ? stall_len + CNT_W'(1) : '0;
		end
	end

	app_spm_ignored_a: assert property (
		i_spm_exec && !spm_in_loader |=> !o_flash_erase && !o_flash_write && state == SPMC_IDLE
	) else $error("store instruction from application started an operation");

	loader_start_a: assert property (
		(o_flash_erase || o_flash_write) |-> $past(spm_in_loader) && $past(i_spm_exec)
	) else $error("operation started without loader store instruction");

	halt_stall_a: assert property (
		start_op && tgt_in_halt |=> o_core_stall [*8]
	) else $error("halting region operation did not stall the core");

	rww_no_stall_a: assert property (
		state == SPMC_RWW_OP && i_fetch_page >= HALT_BASE |-> o_fetch_valid && !o_core_stall
	) else $error("halting region fetch refused during region operation");

	loader_in_halt_a: assert property (
		ldr_base >= HALT_BASE
	) else $error("loader section leaves the halting region");

	busy_flag_a: assert property (
		start_op && !tgt_in_halt |=> rww_blocked
	) else $error("busy flag not set by region operation");

	rww_fetch_gate_a: assert property (
		(state != SPMC_IDLE || rww_blocked) && i_fetch_page < HALT_BASE |-> !o_fetch_valid
	) else $error("region code handed out while blocked");

	full_duration_a: assert property (
		$fell(o_core_stall) |-> $past(stall_len) == OP_LAST
	) else $error("stall released before operation completed");

	block_hold_a: assert property (
		state != SPMC_IDLE && rww_blocked |=> rww_blocked
	) else $error("busy flag cleared during an operation");

	arm_window_a: assert property (
		wr_ctrl && i_hwdata[`SPMC_CTRL_EN] && !i_spm_exec |=> arm_cnt == `SPMC_ARM_CYCLES
	) else $error("arming window not opened at four cycles");

	lock_block_a: assert property (
		lock_hit |=> !o_flash_erase && !o_flash_write
	) else $error("locked section was programmed");

	split_fuse_a: assert property (
		i_boot_size_fuses == 2'b11 |-> ldr_size == LDR_MIN
	) else $error("loader split does not follow the fuses");

endmodule

// >>> test/spmc_core_model.sv
// ----------------------------------------
// Core model issuing store instructions
// ----------------------------------------
module spmc_core_model #(
	parameter int PAGE_AW = 10
) (
	// Clock
	input wire logic i_sys_clk,
	// Core requests
	output logic o_spm_exec,
	output logic [PAGE_AW-1:0] o_spm_pc_page,
	output logic [PAGE_AW-1:0] o_fetch_page
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle core; no interrupt vectors, so none can land in a blocked page
	initial begin
		o_spm_exec = 1'b0;
		o_spm_pc_page = '0;
		o_fetch_page = '0;
	end

	// Store pulse one edge after the call; inside the four-edge arm window when called no more than two edges after arming
	task automatic store(input logic [PAGE_AW-1:0] pc);
		@(posedge i_sys_clk);
		o_spm_exec <= 1'b1;
		o_spm_pc_page <= pc;
		@(posedge i_sys_clk);
		o_spm_exec <= 1'b0;
		o_spm_pc_page <= ~pc; // Page means nothing outside the pulse
	endtask

	// Fetch query; callers only use its answer, never the blocked code
	task automatic look(input logic [PAGE_AW-1:0] p);
		@(posedge i_sys_clk);
		o_fetch_page <= p;
		@(posedge i_sys_clk);
		#1;
	endtask
endmodule

// >>> test/spmc_core_tb.sv
`include "spmc_defs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module spmc_core_tb;
	import spmc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int OPC = 20; // Short operation time keeps the run brief
	int err_count = 0;
	int comparisons = 0;
	logic clk, rst_b, hsel, hwrite, hready, spm_exec, fetch_valid, stall, erase, write;
	logic [1:0] htrans, boot_sz, app_lk, ldr_lk;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [9:0] pc_page, fetch_page, flash_page;
	logic hresp;

	spmc_core #(.OP_CYCLES(OPC)) uut (
		.i_sys_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_spm_exec(spm_exec), .i_spm_pc_page(pc_page), .i_fetch_page(fetch_page),
		.o_fetch_valid(fetch_valid), .o_core_stall(stall),
		.i_boot_size_fuses(boot_sz), .i_app_lock_bits(app_lk),
		.i_loader_lock_bits(ldr_lk), .o_flash_erase(erase), .o_flash_write(write),
		.o_flash_page(flash_page)
	);
	spmc_core_model #(.PAGE_AW(10)) m (
		.i_sys_clk(clk), .o_spm_exec(spm_exec), .o_spm_pc_page(pc_page),
		.o_fetch_page(fetch_page)
	);

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Bus and operation helpers
	// ----------------------------------------
	// Single word transfer; holds each phase until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	// Arm, store, check strobes; halting ops are timed to their end
	task automatic run_op(input logic [2:0] cmd, input logic [9:0] tgt, input logic [9:0] pc,
		input logic go, input logic halt);
		int n;
		n = 0;
		bus(1'b1, `SPMC_PAGE_OFS, {22'h000000, tgt});
		bus(1'b1, `SPMC_CTRL_OFS, {29'h00000000, cmd});
		m.store(pc);
		#1;
		`CHK(erase, go & cmd[1])
		`CHK(write, go & cmd[2])
		`CHK(stall, go & halt)
		if (go) begin
			`CHK(flash_page, tgt)
		end
		while (stall === 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (go & halt) begin
			`CHK(n, OPC)
		end
	endtask

	// Wait for the sequencer to go idle, then drop the busy flag
	task automatic finish_rww();
		int k;
		k = 0;
		do begin
			bus(1'b0, `SPMC_STAT_OFS, 32'h00000000);
			k++;
		end while (rd[`SPMC_STAT_ACTIVE] !== 1'b0 && k < 40);
		`CHK(rd[`SPMC_STAT_ACTIVE], 1'b0)
		bus(1'b0, `SPMC_CTRL_OFS, 32'h00000000);
		`CHK(rd[`SPMC_CTRL_BUSY], 1'b1)
		bus(1'b1, `SPMC_CTRL_OFS, 32'h00000010);
		bus(1'b0, `SPMC_CTRL_OFS, 32'h00000000);
		`CHK(rd[`SPMC_CTRL_BUSY], 1'b0)
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset state, fuse view, unmapped place
	task automatic t_reset();
		#1;
		`CHK({fetch_valid, stall, erase, write}, 4'h8)
		`CHK({hready, hresp}, 2'b10)
		bus(1'b0, `SPMC_STAT_OFS, 32'h00000000);
		`CHK(rd, 32'h00000000)
		bus(1'b1, `SPMC_FUSE_OFS, 32'hFFFFFFFF);
		bus(1'b0, `SPMC_FUSE_OFS, 32'h00000000);
		`CHK(rd[5:0], {ldr_lk, app_lk, boot_sz})
		bus(1'b0, 8'h10, 32'h00000000);
		`CHK(rd, 32'h00000000)
		$display("test reset done");
	endtask

	// Store from application code does nothing but flag it
	task automatic t_app();
		run_op(3'h3, 10'h3CA, 10'h064, 1'b0, 1'b0);
		bus(1'b0, `SPMC_STAT_OFS, 32'h00000000);
		`CHK(rd[`SPMC_STAT_IGNORED], 1'b1)
		bus(1'b1, `SPMC_STAT_OFS, 32'h00000018);
		$display("test app store done");
	endtask

	// Halting page erase stalls the core and blocks halting fetches
	task automatic t_halt();
		m.look(10'h3E8);
		fork
			run_op(3'h3, 10'h3CA, 10'h3FC, 1'b1, 1'b1);
			begin
				// Two bus writes and the store take eight edges; look well inside
				repeat (12) @(posedge clk);
				#1;
				`CHK(fetch_valid, 1'b0)
			end
		join
		`CHK(fetch_valid, 1'b1)
		$display("test halt erase done");
	endtask

	// READ_WHILE_WRITE_REGION page erase: core runs from halting pages, READ_WHILE_WRITE_REGION blocked till cleared
	task automatic t_rww();
		m.look(10'h005);
		run_op(3'h3, 10'h005, 10'h3FC, 1'b1, 1'b0);
		`CHK(fetch_valid, 1'b0)
		bus(1'b0, `SPMC_CTRL_OFS, 32'h00000000);
		`CHK(rd[`SPMC_CTRL_BUSY], 1'b1)
		m.look(10'h3E8);
		`CHK({fetch_valid, stall}, 2'b10)
		m.look(10'h005);
		`CHK(fetch_valid, 1'b0)
		finish_rww();
		m.look(10'h005);
		`CHK(fetch_valid, 1'b1)
		$display("test rww erase done");
	endtask

	// Every loader size, then writes on both sides of the fixed region boundary
	task automatic t_loader();
		logic [9:0] base;
		for (int f = 0; f < 4; f++) begin
			boot_sz <= 2'(f);
			// Code 00 is the largest loader, each step up halves it
			base = 10'(11'h400 - (11'h004 << (3 - f)));
			run_op(3'h5, 10'h3FF, base - 10'h001, 1'b0, 1'b0);
			run_op(3'h5, 10'h3FF, base, 1'b1, 1'b1);
		end
		run_op(3'h5, 10'h3C0, 10'h3FC, 1'b1, 1'b1);
		run_op(3'h5, 10'h3BF, 10'h3FC, 1'b1, 1'b0);
		finish_rww();
		bus(1'b1, `SPMC_STAT_OFS, 32'h00000018);
		$display("test loader sizes done");
	endtask

	// Each lock group guards its own section only
	task automatic t_locks();
		app_lk <= 2'b10;
		run_op(3'h3, 10'h005, 10'h3FC, 1'b0, 1'b0);
		bus(1'b0, `SPMC_STAT_OFS, 32'h00000000);
		`CHK(rd[`SPMC_STAT_LOCKED], 1'b1)
		bus(1'b1, `SPMC_STAT_OFS, 32'h00000018);
		run_op(3'h3, 10'h3FD, 10'h3FC, 1'b1, 1'b1);
		app_lk <= 2'b11;
		ldr_lk <= 2'b10;
		run_op(3'h3, 10'h3FD, 10'h3FC, 1'b0, 1'b0);
		bus(1'b0, `SPMC_STAT_OFS, 32'h00000000);
		`CHK(rd[`SPMC_STAT_LOCKED], 1'b1)
		bus(1'b1, `SPMC_STAT_OFS, 32'h00000018);
		run_op(3'h3, 10'h005, 10'h3FC, 1'b1, 1'b0);
		finish_rww();
		$display("test lock groups done");
	endtask

	// Arming window: one edge late, an invalid command, then the last allowed edge
	task automatic t_window();
		bus(1'b1, `SPMC_PAGE_OFS, 32'h000003CA);
		bus(1'b1, `SPMC_CTRL_OFS, 32'h00000003);
		repeat (3) @(posedge clk);
		m.store(10'h3FC);
		#1;
		`CHK({erase, write, stall}, 3'b000)
		bus(1'b1, `SPMC_CTRL_OFS, 32'h00000007);
		m.store(10'h3FC);
		#1;
		`CHK({erase, write, stall}, 3'b000)
		bus(1'b1, `SPMC_CTRL_OFS, 32'h00000003);
		repeat (2) @(posedge clk);
		m.store(10'h3FC);
		#1;
		`CHK({erase, write, stall}, 3'b101)
		repeat (OPC - 1) @(posedge clk);
		#1;
		`CHK(stall, 1'b1)
		@(posedge clk);
		#1;
		`CHK(stall, 1'b0)
		$display("test arm window done");
	endtask

	// Closing report
	task automatic results();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog, well above the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		results();
	end

	// Main sequence
	initial begin
		{rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		boot_sz = 2'b11;
		app_lk = 2'b11;
		ldr_lk = 2'b11;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_app();
		t_halt();
		t_rww();
		t_loader();
		t_locks();
		t_window();
		results();
	end
endmodule
